/* File: hdl/pbg_consts.vh */
// constants for the self-test packet generator and checker counters
`ifndef PBG_CONSTS_VH
`define PBG_CONSTS_VH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define PBG_ADDR_BYTE_TOTAL    8'h71
`define PBG_ADDR_ERR_FLAGS     8'h72
`define PBG_ADDR_PKT_LEN       8'h7B
`define PBG_ADDR_GAP_LEN       8'h7C
`define PBG_ADDR_CTRL          8'h80
`define PBG_ADDR_IRQ_STATUS    8'h81
`define PBG_ADDR_IRQ_MASK      8'h82

// ----------------------------------------
// field positions
// ----------------------------------------
`define PBG_BIT_LOCK           0
`define PBG_BIT_LOCK_CLEAR     1
`define PBG_BIT_BYTE_OVF       9
`define PBG_BIT_PKT_OVF        10
`define PBG_BIT_CTRL_GEN_EN    0
`define PBG_BIT_CTRL_COUNT_MD  1
`define PBG_BIT_IRQ_PKT_OVF    0
`define PBG_BIT_IRQ_BYTE_OVF   1
`define PBG_BIT_IRQ_PKT_DONE   2

// ----------------------------------------
// reset values and frame constants
// ----------------------------------------
`define PBG_RST_PKT_LEN        16'h05DC
`define PBG_RST_GAP_LEN        8'h7D
`define PBG_PREAMBLE_NIBBLES   5'h0D
`define PBG_PREAMBLE_NIBBLE    4'h5
`define PBG_SFD_BYTE           8'hD5
`define PBG_GAP_BYTES_PER_STEP 10'h004
`define PBG_ERR_SAT            8'hFF
`define PBG_BYTE_SAT           16'hFFFF

`endif

/* File: hdl/pbg_sat_counter.v */
// counter that saturates or wraps and reports overflow
`timescale 1ns/1ps
`default_nettype none

module pbg_sat_counter #(
    parameter WIDTH = 16
) (
    input  wire             clock,
    input  wire             sys_rst,
    input  wire             clear,
    input  wire             incr,
    input  wire             saturate,
    output reg  [WIDTH-1:0] count,
    output wire             overflow
);
    wire at_max;

    // all ones marks the top of the range
    assign at_max   = &count;
    assign overflow = incr & at_max & ~clear;

    // --------------------------------
    // count with clear winning
    // --------------------------------
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            count <= {WIDTH{1'b0}};
        end else if (clear) begin
            count <= {WIDTH{1'b0}};
        end else if (incr && !(saturate && at_max)) begin
            count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
endmodule

`default_nettype wire

/* File: hdl/pbg_selftest.v */
// self-test packet generator and checker counters with register port
//
// Function
// R1 - packet counter overflow sets flag bit 10
// R2 - byte counter overflow sets flag bit 9
// R3 - overflow flags cleared only by clear write
// R4 - errored bytes counted in bits 7:0
// R5 - count mode zero saturates errors at FF
// R6 - bit 0 write locks reported counters
// R7 - bit 1 write locks then clears counters
// R8 - packet length from register, reset 1500
// R9 - thirteen 5 nibbles then D5 precede packet
// R10 - gap between packets, field reset 7D
// R11 - gap bytes equal four times field
// R12 - 16-bit byte total, locked, saturating; here it saturates only in count mode zero and wraps in mode one
// R13 - snapshot holds until next lock write
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "pbg_consts.vh"

module pbg_selftest #(
    parameter PKT_CNT_WIDTH = 16
) (
    input  wire        clock,
    input  wire        sys_rst,
    input  wire [7:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_write,
    input  wire        reg_read,
    output reg  [15:0] reg_rdata,
    output wire        irq,
    output reg  [3:0]  gen_nibble,
    output reg         gen_nibble_valid,
    output reg         gen_frame_active,
    input  wire        chk_byte_valid,
    input  wire        chk_byte_error,
    input  wire        chk_packet_end
);
    // --------------------------------
    // state codes of the generator
    // --------------------------------
    localparam ST_IDLE     = 2'd0;
    localparam ST_PREAMBLE = 2'd1;
    localparam ST_PAYLOAD  = 2'd2;
    localparam ST_GAP      = 2'd3;

    // --------------------------------
    // frame constants
    // --------------------------------
    localparam [7:0]  SFD_BYTE = `PBG_SFD_BYTE;
    localparam [16:0] PRE_NIBS = {12'h000, `PBG_PREAMBLE_NIBBLES};

    // software-visible registers
    reg  [15:0] test_packet_length;
    reg  [7:0]  gap_length_field;
    reg         gen_enable;
    reg         checker_count_mode;
    reg  [2:0]  irq_status;
    reg  [2:0]  irq_mask;

    // checker snapshot and flags
    reg         packet_counter_overflow_flag;
    reg         byte_counter_overflow_flag;
    reg  [15:0] received_byte_total;
    reg  [7:0]  errored_byte_count;

    // generator state
    reg  [1:0]  state;
    reg  [16:0] nib_cnt;
    reg  [7:0]  prbs;
    reg         pkt_done;

    // strobes, live counts and lengths
    wire        wr_flags;
    wire        lock;
    wire        clear;
    wire        saturate;
    wire [15:0] live_bytes;
    wire [7:0]  live_errs;
    wire [PKT_CNT_WIDTH-1:0] live_pkts;
    wire        byte_ovf;
    wire        pkt_ovf;
    wire [16:0] payload_nibbles;
    wire [16:0] gap_nibbles;
    wire [2:0]  irq_events;

    // --------------------------------
    // lock and clear strobes
    // --------------------------------
    assign wr_flags = reg_write && (reg_addr == `PBG_ADDR_ERR_FLAGS);
    assign lock  = wr_flags && (reg_wdata[`PBG_BIT_LOCK] || reg_wdata[`PBG_BIT_LOCK_CLEAR]); // R6
    assign clear = wr_flags && reg_wdata[`PBG_BIT_LOCK_CLEAR]; // R7

    // count mode zero stops the byte and error counters at the top; the packet counter always wraps
    assign saturate = ~checker_count_mode; // R5

    // --------------------------------
    // checker counters
    // --------------------------------
    pbg_sat_counter #(.WIDTH(16)) u_byte_cnt (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .clear    (clear),
        .incr     (chk_byte_valid),
        .saturate (saturate), // R12
        .count    (live_bytes),
        .overflow (byte_ovf)
    );

    pbg_sat_counter #(.WIDTH(8)) u_err_cnt (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .clear    (clear),
        .incr     (chk_byte_valid & chk_byte_error), // R4
        .saturate (saturate), // R5
        .count    (live_errs),
        .overflow ()
    );

    pbg_sat_counter #(.WIDTH(PKT_CNT_WIDTH)) u_pkt_cnt (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .clear    (clear),
        .incr     (chk_packet_end),
        .saturate (1'b0),
        .count    (live_pkts),
        .overflow (pkt_ovf)
    );

    // --------------------------------
    // snapshot of the live counts
    // --------------------------------
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            received_byte_total <= 16'h0000;
            errored_byte_count  <= 8'h00;
        end else if (lock) begin
            received_byte_total <= live_bytes; // R12 R13
            errored_byte_count  <= live_errs;  // R4 R13
        end
    end

    // --------------------------------
    // overflow flags
    // --------------------------------
    // clear is the only way down; a clearing counter reports no overflow
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            packet_counter_overflow_flag <= 1'b0;
            byte_counter_overflow_flag   <= 1'b0;
        end else if (clear) begin
            packet_counter_overflow_flag <= 1'b0; // R3
            byte_counter_overflow_flag   <= 1'b0; // R3
        end else begin
            if (pkt_ovf) begin
                packet_counter_overflow_flag <= 1'b1; // R1
            end
            if (byte_ovf) begin
                byte_counter_overflow_flag <= 1'b1; // R2
            end
        end
    end

    // --------------------------------
    // generator lengths in nibbles
    // --------------------------------
    assign payload_nibbles = {test_packet_length, 1'b0}; // R8

    // four bytes per field step, two nibbles per byte
    assign gap_nibbles = {6'h00, gap_length_field, 3'h0}; // R11

    // --------------------------------
    // packet generator sequence
    // --------------------------------
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state            <= ST_IDLE;
            nib_cnt          <= 17'h00000;
            prbs             <= 8'hFF;
            gen_nibble       <= 4'h0;
            gen_nibble_valid <= 1'b0;
            gen_frame_active <= 1'b0;
            pkt_done         <= 1'b0;
        end else begin
            pkt_done <= 1'b0;
            case (state)
                ST_IDLE: begin
                    gen_nibble_valid <= 1'b0;
                    gen_frame_active <= 1'b0;
                    nib_cnt          <= 17'h00000;
                    if (gen_enable) begin
                        state <= ST_PREAMBLE;
                    end
                end
                ST_PREAMBLE: begin
                    gen_nibble_valid <= 1'b1;
                    gen_frame_active <= 1'b1;
                    // 13 nibbles of 5, then D5 low then high nibble
                    if (nib_cnt < PRE_NIBS) begin
                        gen_nibble <= `PBG_PREAMBLE_NIBBLE; // R9
                        nib_cnt    <= nib_cnt + 17'h00001;
                    end else if (nib_cnt == PRE_NIBS) begin
                        gen_nibble <= SFD_BYTE[3:0]; // R9
                        nib_cnt    <= nib_cnt + 17'h00001;
                    end else begin
                        gen_nibble <= SFD_BYTE[7:4]; // R9
                        nib_cnt    <= 17'h00000;
                        state      <= (payload_nibbles == 17'h00000) ? ST_GAP : ST_PAYLOAD;
                    end
                end
                ST_PAYLOAD: begin
                    // one pseudo-random nibble per cycle
                    gen_nibble <= prbs[3:0];
                    prbs       <= {prbs[6:0], prbs[7] ^ prbs[5] ^ prbs[4] ^ prbs[3]};
                    if (nib_cnt == payload_nibbles - 17'h00001) begin
                        nib_cnt  <= 17'h00000; // R8
                        state    <= ST_GAP;
                        pkt_done <= 1'b1;
                    end else begin
                        nib_cnt <= nib_cnt + 17'h00001;
                    end
                end
                ST_GAP: begin
                    // outputs idle while the gap runs
                    gen_nibble_valid <= 1'b0;
                    gen_frame_active <= 1'b0;
                    gen_nibble       <= 4'h0;
                    if (nib_cnt + 17'h00001 >= gap_nibbles) begin
                        nib_cnt <= 17'h00000; // R10
                        state   <= gen_enable ? ST_PREAMBLE : ST_IDLE;
                    end else begin
                        nib_cnt <= nib_cnt + 17'h00001; // R11
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // --------------------------------
    // software registers and interrupt
    // --------------------------------
    // events that set the sticky status bits
    assign irq_events = {pkt_done, byte_ovf, pkt_ovf};

    // level interrupt while an unmasked bit is set
    assign irq = |(irq_status & irq_mask);

    // configuration registers
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            test_packet_length <= `PBG_RST_PKT_LEN; // R8
            gap_length_field   <= `PBG_RST_GAP_LEN; // R10
            gen_enable         <= 1'b0;
            checker_count_mode <= 1'b0;
            irq_mask           <= 3'h0;
        end else if (reg_write) begin
            case (reg_addr)
                `PBG_ADDR_PKT_LEN: test_packet_length <= reg_wdata; // R8
                `PBG_ADDR_GAP_LEN: gap_length_field <= reg_wdata[7:0]; // R10
                `PBG_ADDR_CTRL: begin
                    gen_enable         <= reg_wdata[`PBG_BIT_CTRL_GEN_EN];
                    checker_count_mode <= reg_wdata[`PBG_BIT_CTRL_COUNT_MD];
                end
                `PBG_ADDR_IRQ_MASK: irq_mask <= reg_wdata[2:0];
                default: ;
            endcase
        end
    end

    // sticky status; a new event wins over the write-one clear
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            irq_status <= 3'h0;
        end else if (reg_write && reg_addr == `PBG_ADDR_IRQ_STATUS) begin
            irq_status <= (irq_status & ~reg_wdata[2:0]) | irq_events;
        end else begin
            irq_status <= irq_status | irq_events;
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_read) begin
            case (reg_addr)
                `PBG_ADDR_BYTE_TOTAL: reg_rdata <= received_byte_total;
                `PBG_ADDR_ERR_FLAGS: reg_rdata <= {5'h00, packet_counter_overflow_flag,
                                                   byte_counter_overflow_flag, 1'b0,
                                                   errored_byte_count};
                `PBG_ADDR_PKT_LEN: reg_rdata <= test_packet_length;
                `PBG_ADDR_GAP_LEN: reg_rdata <= {8'h00, gap_length_field};
                `PBG_ADDR_CTRL: reg_rdata <= {14'h0000, checker_count_mode, gen_enable};
                `PBG_ADDR_IRQ_STATUS: reg_rdata <= {13'h0000, irq_status};
                `PBG_ADDR_IRQ_MASK: reg_rdata <= {13'h0000, irq_mask};
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end
endmodule

`default_nettype wire

/* File: verif/pbg_selftest_properties.sv */
// port assertions for the self-test generator and checker block
`timescale 1ns/1ps
`default_nettype none
`include "pbg_consts.vh"
module pbg_selftest_properties (
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic [7:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [15:0] reg_rdata,
    input wire logic [3:0]  gen_nibble,
    input wire logic        gen_nibble_valid,
    input wire logic        gen_frame_active
);
    logic [31:0] nib;
    logic [31:0] idle;
    logic        had;
    logic [15:0] len;
    logic [7:0]  gap;
    // nibble index, idle run and shadow copies of length and gap
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            nib  <= 32'h0;
            idle <= 32'h0;
            had  <= 1'b0;
            len  <= `PBG_RST_PKT_LEN;
            gap  <= `PBG_RST_GAP_LEN;
        end else begin
            nib  <= gen_nibble_valid ? nib + 32'h1 : 32'h0;
            idle <= gen_nibble_valid ? 32'h0 : idle + 32'h1;
            if (!gen_nibble_valid && nib != 32'h0)
                had <= 1'b1;
            if (reg_write && reg_addr == `PBG_ADDR_PKT_LEN)
                len <= reg_wdata;
            if (reg_write && reg_addr == `PBG_ADDR_GAP_LEN)
                gap <= reg_wdata[7:0];
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    property p_preamble;
        gen_nibble_valid && nib < 32'd14 |-> gen_nibble == `PBG_PREAMBLE_NIBBLE;
    endproperty
    a_preamble: assert property (p_preamble) else $error("preamble nibble wrong");
    property p_sfd_high;
        gen_nibble_valid && nib == 32'd14 |-> gen_nibble == 4'hD;
    endproperty
    a_sfd_high: assert property (p_sfd_high) else $error("frame start nibble wrong");
    property p_pkt_len;
        $fell(gen_nibble_valid) |-> nib == 32'd15 + 32'd2 * len;
    endproperty
    a_pkt_len: assert property (p_pkt_len) else $error("packet length wrong");
    property p_gap;
        $rose(gen_nibble_valid) && had |-> idle == 32'd8 * gap;
    endproperty
    a_gap: assert property (p_gap) else $error("gap length wrong");
    property p_frame;
        gen_frame_active == gen_nibble_valid;
    endproperty
    a_frame: assert property (p_frame) else $error("frame flag differs from valid");
    property p_len_rw;
        reg_write && reg_addr == `PBG_ADDR_PKT_LEN ##1 reg_read && reg_addr == `PBG_ADDR_PKT_LEN
            |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_len_rw: assert property (p_len_rw) else $error("length readback wrong");
    property p_gap_rw;
        reg_write && reg_addr == `PBG_ADDR_GAP_LEN ##1 reg_read && reg_addr == `PBG_ADDR_GAP_LEN
            |=> reg_rdata == ($past(reg_wdata, 2) & 16'h00FF);
    endproperty
    a_gap_rw: assert property (p_gap_rw) else $error("gap readback wrong");
    property p_rsvd;
        reg_read && reg_addr == `PBG_ADDR_ERR_FLAGS |=> reg_rdata[15:11] == 5'h00 && !reg_rdata[8];
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved flag bits set");
    c_pkt: cover property ($fell(gen_nibble_valid));
    c_gap: cover property ($rose(gen_nibble_valid) && had);
    c_rd: cover property (reg_read && reg_addr == `PBG_ADDR_ERR_FLAGS);
endmodule
`default_nettype wire

/* File: verif/pbg_link_model.sv */
// far side model feeding received bytes to the checker
`timescale 1ns/1ps
`default_nettype none
module pbg_link_model (
    input  wire logic clock,
    output var  logic chk_byte_valid,
    output var  logic chk_byte_error,
    output var  logic chk_packet_end
);
    initial begin
        chk_byte_valid = 1'b0;
        chk_byte_error = 1'b0;
        chk_packet_end = 1'b0;
    end
    // one byte per cycle, first nerr bytes errored, end pulse on last byte
    task automatic send(input int n, input int nerr);
        for (int i = 0; i < n; i++) begin
            chk_byte_valid <= 1'b1;
            chk_byte_error <= (i < nerr);
            chk_packet_end <= (i == n - 1);
            @(posedge clock);
        end
        chk_byte_valid <= 1'b0;
        chk_byte_error <= ~chk_byte_error; // junk while unqualified
        chk_packet_end <= 1'b0;
        @(posedge clock);
    endtask
endmodule
`default_nettype wire

/* File: verif/prbs_bist_packet_gen_check_bench.sv */
// self-checking bench for the self-test generator and checker block
`timescale 1ns/1ps
`default_nettype none
module prbs_bist_packet_gen_check_bench;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    wire [15:0] reg_rdata;
    wire irq, gen_nibble_valid, gen_frame_active, chk_byte_valid, chk_byte_error, chk_packet_end;
    wire [3:0] gen_nibble;
    int err_total = 0;
    int n_compared = 0;
    always #2.5 clock = ~clock;
    pbg_selftest #(.PKT_CNT_WIDTH(4)) dut_u (.clock(clock), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq), .gen_nibble(gen_nibble),
        .gen_nibble_valid(gen_nibble_valid), .gen_frame_active(gen_frame_active),
        .chk_byte_valid(chk_byte_valid), .chk_byte_error(chk_byte_error),
        .chk_packet_end(chk_packet_end));
    pbg_link_model link_u (.clock(clock), .chk_byte_valid(chk_byte_valid),
        .chk_byte_error(chk_byte_error), .chk_packet_end(chk_packet_end));
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_write <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        reg_read <= 1'b1; reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic wait_irq;
        int k;
        k = 0;
        while (irq !== 1'b1 && k < 400) begin
            @(posedge clock); #1 k++;
        end
        if (k == 400) begin err_total++; end_of_test; end
    endtask
    logic [15:0] v;
    initial begin
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        // reset values, reserved and unmapped places
        wr(8'h10, 16'hFFFF); wr(8'h7C, 16'hFF12);
        rd(8'h7C, v); chk(v, 16'h0012);
        wr(8'h7C, 16'h007D);
        rd(8'h7B, v); chk(v, 16'h05DC);
        rd(8'h72, v); chk(v, 16'h0000);
        rd(8'h10, v); chk(v, 16'h0000);
        $display("test defaults done");
        // lock, hold, lock with clear
        link_u.send(5, 3); wr(8'h72, 16'h0001);
        rd(8'h72, v); chk(v, 16'h0003);
        rd(8'h71, v); chk(v, 16'h0005);
        link_u.send(2, 2);
        rd(8'h72, v); chk(v, 16'h0003);
        wr(8'h72, 16'h0002);
        rd(8'h72, v); chk(v, 16'h0005);
        rd(8'h71, v); chk(v, 16'h0007);
        wr(8'h72, 16'h0001);
        rd(8'h72, v); chk(v, 16'h0000);
        rd(8'h71, v); chk(v, 16'h0000);
        $display("test lock done");
        // errored byte count saturation
        link_u.send(260, 260); wr(8'h72, 16'h0001);
        rd(8'h72, v); chk(v, 16'h00FF);
        rd(8'h71, v); chk(v, 16'h0104);
        wr(8'h72, 16'h0002);
        $display("test saturate done");
        // wrap mode: errored count rolls over past FF
        wr(8'h80, 16'h0002); link_u.send(258, 258); wr(8'h72, 16'h0002);
        rd(8'h72, v); chk(v, 16'h0002);
        rd(8'h71, v); chk(v, 16'h0102);
        wr(8'h80, 16'h0000);
        $display("test wrap done");
        // both counters overflow, interrupt, clear of flags
        link_u.send(65536, 0);
        repeat (15) link_u.send(1, 0);
        wr(8'h72, 16'h0001);
        rd(8'h72, v); chk(v, 16'h0600);
        rd(8'h71, v); chk(v, 16'hFFFF);
        chk({15'h0, irq}, 16'h0000);
        wr(8'h82, 16'h0001); chk({15'h0, irq}, 16'h0001);
        rd(8'h81, v); chk(v, 16'h0003);
        wr(8'h81, 16'h0001); chk({15'h0, irq}, 16'h0000);
        rd(8'h72, v); chk(v, 16'h0600);
        wr(8'h72, 16'h0002); wr(8'h72, 16'h0001);
        rd(8'h72, v); chk(v, 16'h0000);
        $display("test overflow done");
        // generator with short packets and gap
        wr(8'h7B, 16'h0003); rd(8'h7B, v); chk(v, 16'h0003);
        wr(8'h7C, 16'h0001); rd(8'h7C, v); chk(v, 16'h0001);
        wr(8'h81, 16'h0007); wr(8'h82, 16'h0004); wr(8'h80, 16'h0001);
        wait_irq; chk({15'h0, irq}, 16'h0001);
        wr(8'h81, 16'h0004);
        wait_irq; wr(8'h80, 16'h0000);
        repeat (100) @(posedge clock);
        $display("test generator done");
        end_of_test;
    end
endmodule
bind pbg_selftest pbg_selftest_properties chk_u (.clock(clock), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .gen_nibble(gen_nibble), .gen_nibble_valid(gen_nibble_valid),
    .gen_frame_active(gen_frame_active));
`default_nettype wire
